// *** bench/rwd_apb_host.sv ***
// Bus master model standing in for the cores
`timescale 1ns/1ps
module rwd_apb_host (
	// Clock
	input wire logic clk,
	// Bus
	output rwd_pkg::rwd_apb_req_t apbReq,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial apbReq = '0;
	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] r, output logic e);
		@(posedge clk) #1;
		apbReq = '{1'b1, 1'b0, w, a, d};
		@(posedge clk) #1;
		apbReq.penable = 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		// Released lines toggle so stale data cannot pass
		#1 apbReq = '{1'b0, 1'b0, w, ~a, ~d};
	endtask
endmodule

// *** bench/rwd_watchdog_chk.sv ***
// Watchdog port assertions
`timescale 1ns/1ps
`include "rwd_map.svh"
module rwd_watchdog_chk (
	input wire logic clk,
	input wire logic reset,
	input wire rwd_pkg::rwd_apb_req_t apbReq,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [2:0] debugHalt,
	input wire logic core0TimeoutPulse,
	input wire logic core1TimeoutPulse,
	input wire logic mcuTimeoutPulse
);
	logic [2:0] tp;
	logic ac, wr;
	assign tp = {mcuTimeoutPulse, core1TimeoutPulse, core0TimeoutPulse};
	assign ac = apbReq.psel & apbReq.penable;
	assign wr = ac & apbReq.pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Output trails the internal pulse by one cycle, so halt must last two
	property p_h0; debugHalt[0] && $past(debugHalt[0]) |=> !tp[0];
	endproperty
	a_h0: assert property (p_h0) else $error("h0");
	property p_h1; debugHalt[1] && $past(debugHalt[1]) |=> !tp[1];
	endproperty
	a_h1: assert property (p_h1) else $error("h1");
	property p_h2; debugHalt[2] && $past(debugHalt[2]) |=> !tp[2];
	endproperty
	a_h2: assert property (p_h2) else $error("h2");
	property p_w0;
		$rose(tp[0]) && !$past(wr) && !$past(debugHalt[0]) |=> tp[0];
	endproperty
	a_w0: assert property (p_w0) else $error("w0");
	property p_w1;
		$rose(tp[1]) && !$past(wr) && !$past(debugHalt[1]) |=> tp[1];
	endproperty
	a_w1: assert property (p_w1) else $error("w1");
	property p_r; ac && !apbReq.pwrite && !pslverr |-> prdata[31:14] == '0;
	endproperty
	a_r: assert property (p_r) else $error("r");
	property p_t0; wr && apbReq.paddr == `RWD_CORE0_ADDR |-> ##2 !tp[0];
	endproperty
	a_t0: assert property (p_t0) else $error("t0");
	property p_t1; wr && apbReq.paddr == `RWD_CORE1_ADDR |-> ##2 !tp[1];
	endproperty
	a_t1: assert property (p_t1) else $error("t1");
endmodule
bind rwd_watchdog rwd_watchdog_chk u_chk (.clk, .reset, .apbReq, .prdata,
	.pslverr, .debugHalt, .core0TimeoutPulse, .core1TimeoutPulse,
	.mcuTimeoutPulse);

// *** bench/rwd_watchdog_tb.sv ***
// Bench of the watchdog
`timescale 1ns/1ps
`include "rwd_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
num_errors++; $display("BAD %0t mismatch", $time); end end
module rwd_watchdog_tb;
	logic clk = 1'b0;
	logic reset, pready, pslverr, err;
	logic [2:0] debugHalt;
	wire [2:0] tp;
	logic [31:0] prdata, rd;
	rwd_pkg::rwd_apb_req_t apbReq;
	int num_errors, comparisons, c;
	rwd_apb_host u_host (.clk, .apbReq, .prdata, .pready, .pslverr);
	rwd_watchdog u_dut (.clk, .reset, .apbReq, .prdata, .pready, .pslverr,
		.debugHalt, .core0TimeoutPulse(tp[0]), .core1TimeoutPulse(tp[1]),
		.mcuTimeoutPulse(tp[2]));
	initial forever #10 clk = ~clk;
	task automatic conclude();
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, d, input logic w = 1'b1);
		u_host.xfer(w, a, d, rd, err);
	endtask
	task automatic count(input int ch, n);
		c = 0;
		repeat (n) @(posedge clk) c += tp[ch];
	endtask
	task automatic t_config();
		// Key 10, enable set, divide by two, reload five
		wr(`RWD_CORE0_ADDR, 32'hA005);
		count(0, 18);
		`CHK(c, 2)
		wr(`RWD_CORE0_ADDR, 32'hB00F);
		wr(`RWD_CORE0_ADDR, '0, 1'b0);
		`CHK(rd, 32'h2005)
	endtask
	task automatic t_hold();
		repeat (3) begin
			wr(`RWD_CORE0_ADDR, '0);
			count(0, 3);
			`CHK(c, 0)
		end
		#1 debugHalt = 3'h7;
		count(0, 30);
		`CHK(c, 0)
		#1 debugHalt = 3'h0;
	endtask
	task automatic t_refuse();
		wr(`RWD_CORE1_ADDR, 32'h6005);
		wr(`RWD_CORE1_ADDR, '0, 1'b0);
		`CHK(rd, 32'hFFF)
		wr(`RWD_CORE1_ADDR, 32'hA003);
		count(1, 12);
		`CHK(c, 2)
	endtask
	task automatic t_slow();
		wr(32'h4000_B000, 32'hA001);
		`CHK(err, 1'b1)
		// Divide by 2^14, reload one: pulse right away for one period
		wr(`RWD_MCU_ADDR, 32'hB001);
		count(2, 16390);
		`CHK(c, 16384)
	endtask
	task automatic t_disabled();
		// Mid-run reset, then lock the channel with enable clear
		#1 reset = 1'b1;
		repeat (3) @(posedge clk);
		#1 reset = 1'b0;
		wr(`RWD_CORE0_ADDR, 32'h8001);
		count(0, 10);
		`CHK(c, 0)
		wr(`RWD_CORE0_ADDR, '0, 1'b0);
		`CHK(rd, 32'h0001)
	endtask
	initial begin
		reset = 1'b1;
		debugHalt = 3'h0;
		repeat (3) @(posedge clk);
		#1 reset = 1'b0;
		t_config();
		t_hold();
		t_refuse();
		t_slow();
		t_disabled();
		conclude();
	end
	initial begin
		// Slow-prescale pulse alone spans about 16k cycles
		#1_000_000;
		num_errors++;
		conclude();
	end
endmodule

// *** core/rwd_channel.sv ***
// One watchdog channel: lock-once configuration, prescaler, counter
`timescale 1ns/1ps
`include "rwd_map.svh"
module rwd_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register access
	input wire logic wrStrobe,
	input wire logic [31:0] wrData,
	input wire logic debugHalt,
	// Status
	output rwd_pkg::rwd_cfg_t cfg,
	output logic timeoutPulse
);
	rwd_pkg::rwd_state_t state_r, state_nxt;
	rwd_pkg::rwd_cfg_t cfg_r, cfg_nxt;
	logic [13:0] pre_r, pre_nxt;
	logic [11:0] cnt_r, cnt_nxt;
	logic pulse_r, pulse_nxt;
	logic tick;
	logic keyOk;

	assign cfg = cfg_r;
	assign timeoutPulse = pulse_r;

	always_comb begin
		// Key must match before lower bits may change
		// key check
		keyOk = wrData[`RWD_KEY_MSB:`RWD_KEY_LSB] == `RWD_KEY_VALUE;
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		if (wrStrobe && keyOk && state_r == rwd_pkg::RWD_UNCONFIGURED) begin
			state_nxt = rwd_pkg::RWD_LOCKED;
			cfg_nxt.enable = wrData[`RWD_ENABLE_BIT];
			cfg_nxt.prescale = wrData[`RWD_PRESCALE_BIT];
			cfg_nxt.reload = wrData[`RWD_RELOAD_MSB:0];
		end
	end

	always_comb begin
		tick = 1'b0;
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		pulse_nxt = pulse_r;
		if (cfg_r.enable) begin
			if (pre_r == 14'h0000) begin
				tick = 1'b1;
				pre_nxt = cfg_r.prescale ? `RWD_PRESCALE_SLOW
					: `RWD_PRESCALE_FAST;
			end else begin
				pre_nxt = pre_r - 14'h0001;
			end
		end
		if (cfg_r.enable && tick) begin
			pulse_nxt = 1'b0;
			if (cnt_r == 12'h000) begin
				cnt_nxt = cfg_r.reload;
			end else begin
				cnt_nxt = cnt_r - 12'h001;
				pulse_nxt = (cnt_r == 12'h001) && !debugHalt;
			end
		end
		if (!cfg_r.enable || debugHalt) begin
			pulse_nxt = 1'b0;
		end
		if (wrStrobe) begin
			cnt_nxt = (state_r == rwd_pkg::RWD_UNCONFIGURED)
				? cfg_nxt.reload : cfg_r.reload;
			pulse_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= rwd_pkg::RWD_UNCONFIGURED;
			cfg_r <= '{enable: 1'b0, prescale: 1'b0,
				reload: `RWD_RESET_RELOAD};
			pre_r <= 14'h0000;
			cnt_r <= `RWD_RESET_RELOAD;
			pulse_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			pulse_r <= pulse_nxt;
		end
	end
endmodule

// *** core/rwd_map.svh ***
// Register map and constants of the retriggerable watchdog
`ifndef RWD_MAP_SVH
`define RWD_MAP_SVH
`define RWD_CORE0_ADDR 32'h4000_8000
`define RWD_CORE1_ADDR 32'h4000_9000
`define RWD_MCU_ADDR 32'h4000_A000
`define RWD_PAGE_MASK 32'hFFFF_F000
`define RWD_KEY_MSB 15
`define RWD_KEY_LSB 14
`define RWD_KEY_VALUE 2'h2
`define RWD_ENABLE_BIT 13
`define RWD_PRESCALE_BIT 12
`define RWD_RELOAD_MSB 11
`define RWD_PRESCALE_SLOW 14'h3FFF
`define RWD_PRESCALE_FAST 14'h0001
`define RWD_RESET_RELOAD 12'hFFF
`endif

// *** core/rwd_pkg.sv ***
// Types shared by the watchdog files
package rwd_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} rwd_apb_req_t;
	typedef struct packed {
		logic enable;
		logic prescale;
		logic [11:0] reload;
	} rwd_cfg_t;
	typedef enum logic {
		RWD_UNCONFIGURED,
		RWD_LOCKED
	} rwd_state_t;
endpackage

// *** core/rwd_watchdog.sv ***
// Three-channel watchdog with APB register slave
`timescale 1ns/1ps
`include "rwd_map.svh"
module rwd_watchdog (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire rwd_pkg::rwd_apb_req_t apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Debugger halt per core
	input wire logic [2:0] debugHalt,
	// Timeout pulses
	output logic core0TimeoutPulse,
	output logic core1TimeoutPulse,
	output logic mcuTimeoutPulse
);
	logic [2:0] wrSel;
	logic [2:0] pulse;
	rwd_pkg::rwd_cfg_t cfg [3];
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [2:0] out_r, out_nxt;

	// Decode a bus address into a channel index, 3 when unmapped
	function automatic logic [1:0] chanOf(input logic [31:0] a);
		unique case (a)
			`RWD_CORE0_ADDR: chanOf = 2'h0;
			`RWD_CORE1_ADDR: chanOf = 2'h1;
			`RWD_MCU_ADDR: chanOf = 2'h2;
			default: chanOf = 2'h3;
		endcase
	endfunction

	logic access;
	logic [1:0] chan;
	assign access = apbReq.psel && apbReq.penable;
	assign chan = chanOf(apbReq.paddr);

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gChan
			assign wrSel[g] = access && apbReq.pwrite && chan == 2'(g);
			rwd_channel uChan (
				.clk(clk),
				.reset(reset),
				.wrStrobe(wrSel[g]),
				.wrData(apbReq.pwdata),
				.debugHalt(debugHalt[g]),
				.cfg(cfg[g]),
				.timeoutPulse(pulse[g])
			);
		end
	endgenerate

	always_comb begin
		prdata_nxt = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		out_nxt = pulse;
		if (apbReq.psel && !apbReq.penable) begin
			if (chanOf(apbReq.paddr) == 2'h3) begin
				pslverr_nxt = 1'b1;
			end else if (!apbReq.pwrite) begin
				prdata_nxt[`RWD_ENABLE_BIT] =
					cfg[chanOf(apbReq.paddr)].enable;
				prdata_nxt[`RWD_PRESCALE_BIT] =
					cfg[chanOf(apbReq.paddr)].prescale;
				prdata_nxt[`RWD_RELOAD_MSB:0] =
					cfg[chanOf(apbReq.paddr)].reload;
			end
		end else if (access) begin
			prdata_nxt = prdata_r;
			pslverr_nxt = pslverr_r;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			out_r <= 3'h0;
			pready <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			out_r <= out_nxt;
			pready <= 1'b1;
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign core0TimeoutPulse = out_r[0];
	assign core1TimeoutPulse = out_r[1];
	assign mcuTimeoutPulse = out_r[2];
endmodule
